// ---- src/phy_mgmt_pkg.sv ----
// package: register indices, field positions, reset values for the phy management registers
package phy_mgmt_pkg;
    localparam int REG_W = 16;
    localparam logic [4:0] IDX_STATUS = 5'h01;
    localparam logic [4:0] IDX_IDENT_UPPER = 5'h02;
    localparam logic [4:0] IDX_IDENT_LOWER = 5'h03;
    localparam logic [4:0] IDX_ADVERTISE = 5'h04;
    localparam logic [4:0] IDX_PARTNER = 5'h05;
    // phy bus addresses of the two ports
    localparam logic [4:0] PHY_ADDR_PORT1 = 5'h01;
    localparam logic [4:0] PHY_ADDR_PORT2 = 5'h02;
    // status fields
    localparam int ST_10_HALF = 11;
    localparam int ST_NEG_DONE = 5;
    localparam int ST_FAR_FAULT = 4;
    localparam int ST_NEG_SUPPORTED = 3;
    localparam int ST_LINK_UP = 2;
    localparam int ST_EXTENDED = 0;
    localparam logic [15:0] STATUS_FIXED = 16'h7800; // 100/10 full/half capable always one
    // advertisement fields
    localparam int ADV_PAUSE = 10;
    localparam int ADV_100_FULL = 8;
    localparam int ADV_100_HALF = 7;
    localparam int ADV_10_FULL = 6;
    localparam int ADV_10_HALF = 5;
    localparam logic [15:0] ADV_WRITABLE = 16'h05E0;
    localparam logic [15:0] ADV_RESET = 16'h05E1;
    localparam logic [15:0] ADV_SELECTOR = 16'h0001;
    // partner ability fields
    localparam int LP_PAUSE = 10;
    localparam int LP_ABIL_LO = 5;
    localparam logic [15:0] PARTNER_RESET = 16'h0000;
endpackage : phy_mgmt_pkg

// ---- src/port_regs_if.sv ----
// interface: per-port status and advertise values between the register bank and one port slice
interface port_regs_if;
    logic [15:0] status;
    logic [15:0] advertise;
    logic [15:0] partner;
    logic [15:0] adv_applied;
    logic wr_adv;
    logic [15:0] wdata;
    modport bank (input status, input advertise, input partner, input adv_applied, output wr_adv, output wdata);
    modport slice (output status, output advertise, output partner, output adv_applied, input wr_adv, input wdata);
endinterface : port_regs_if

// ---- src/phy_port_slice.sv ----
// module: register state of one phy port (advertise, status, partner ability)
module phy_port_slice (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // port state, already synchronised
    input wire logic neg_enable,
    input wire logic neg_done,
    input wire logic far_fault,
    input wire logic link_up,
    input wire logic neg_restart,
    input wire logic [4:0] lp_ability,
    // register view
    port_regs_if.slice regs
);
    logic [15:0] advertise;
    logic [15:0] next_advertise;
    logic [15:0] adv_applied;
    logic [15:0] next_adv_applied;
    logic [15:0] partner;
    logic [15:0] next_partner;
    logic neg_done_q;
    logic next_neg_done_q;

    // next values; writes touch only the writable advertise bits
    always_comb begin
        next_advertise = advertise;
        next_adv_applied = adv_applied;
        next_partner = partner;
        next_neg_done_q = neg_done;
        if (regs.wr_adv) begin
            next_advertise = (regs.wdata & phy_mgmt_pkg::ADV_WRITABLE) | phy_mgmt_pkg::ADV_SELECTOR;
        end
        // new advertisement takes effect only at restart, not on a live link
        if (neg_restart) begin
            next_adv_applied = advertise;
        end
        // latch partner ability when negotiation completes
        if (neg_done && !neg_done_q) begin
            next_partner = phy_mgmt_pkg::PARTNER_RESET;
            next_partner[phy_mgmt_pkg::LP_PAUSE] = lp_ability[4];
            next_partner[phy_mgmt_pkg::LP_ABIL_LO +: 4] = lp_ability[3:0];
        end else if (!link_up && !neg_done) begin
            next_partner = phy_mgmt_pkg::PARTNER_RESET;
        end
    end

    // registers only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            advertise <= phy_mgmt_pkg::ADV_RESET;
            adv_applied <= phy_mgmt_pkg::ADV_RESET;
            partner <= phy_mgmt_pkg::PARTNER_RESET;
            neg_done_q <= 1'b0;
        end else if (ce) begin
            advertise <= next_advertise;
            adv_applied <= next_adv_applied;
            partner <= next_partner;
            neg_done_q <= next_neg_done_q;
        end
    end

    // status word assembled from fixed capabilities and live state
    always_comb begin
        regs.status = phy_mgmt_pkg::STATUS_FIXED;
        regs.status[phy_mgmt_pkg::ST_10_HALF] = 1'b1;
        regs.status[phy_mgmt_pkg::ST_NEG_DONE] = neg_done;
        regs.status[phy_mgmt_pkg::ST_FAR_FAULT] = far_fault;
        regs.status[phy_mgmt_pkg::ST_NEG_SUPPORTED] = neg_enable;
        regs.status[phy_mgmt_pkg::ST_LINK_UP] = link_up;
        regs.status[phy_mgmt_pkg::ST_EXTENDED] = 1'b0;
    end

    assign regs.advertise = advertise;
    assign regs.adv_applied = adv_applied;
    assign regs.partner = partner;
endmodule : phy_port_slice

// ---- src/phy_mgmt_regs.sv ----
// module: management register bank for the two integrated phys
// Functional notes
// - status bit 11 always reads 1: 10BASE-T half duplex supported
// - status bit 5 reads 1 once negotiation done, else 0, reset 0
// - status bit 4 shows far-end fault, reset 0
// - status bit 3 mirrors negotiation enable, default 1
// - status bit 0, preamble suppression and jabber test read 0
// - index 2 returns fixed upper identifier half
// - index 3 returns fixed lower identifier half
// - advertise bit 10 writable, default 1, advertises pause
// - advertise bit 8 writable, default 1, advertises 100 full
// - advertise bit 7 writable, default 1, advertises 100 half
// - advertise bit 6 writable, default 1, advertises 10 full
// - advertise bit 5 writable, default 1, advertises 10 half
// - index 5 reports partner ability read-only; next page reads 0
// - partner bit 10 shows partner pause ability from negotiation
module phy_mgmt_regs #(
    parameter logic [15:0] IDENT_UPPER = 16'h1234, // arbitrary value
    parameter logic [15:0] IDENT_LOWER = 16'h5670 // arbitrary value
) (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    // management access, same clock domain
    input wire logic RD,
    input wire logic WR,
    input wire logic [4:0] PHY_BUS_ADDRESS,
    input wire logic [4:0] REGISTER_INDEX,
    input wire logic [15:0] WDATA,
    output logic [15:0] RDATA,
    output logic RVALID,
    // port state pins, asynchronous
    input wire logic [1:0] NEG_ENABLE,
    input wire logic [1:0] NEGOTIATION_DONE,
    input wire logic [1:0] FAR_FAULT,
    input wire logic [1:0] LINK_UP,
    input wire logic [1:0] NEG_RESTART,
    input wire logic [9:0] LP_ABILITY,
    // advertisement in force per port
    output logic [9:0] ADV_ACTIVE
);
    // synchroniser word: done, fault, link, restart two lanes each, then partner ability
    localparam int NSYNC = 18;
    localparam int LANE_DONE = 0;
    localparam int LANE_FAULT = 2;
    localparam int LANE_LINK = 4;
    localparam int LANE_RESTART = 6;
    localparam int LANE_ABILITY = 8;
    localparam int ABIL_W = 5; // pause, 100 full, 100 half, 10 full, 10 half
    // reset and idle values
    localparam logic [1:0] EN_RESET = 2'h3; // negotiation enabled until the pins say otherwise
    localparam logic [15:0] RDATA_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000; // reserved, unmapped or unknown reads

    port_regs_if prt [2] ();
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] raw_in;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [1:0] sel;
    // synchroniser next values
    logic [NSYNC-1:0] next_sync1;
    logic [NSYNC-1:0] next_sync2;
    // access decode
    logic addr_known;
    logic rd_taken;
    logic wr_taken;
    logic hit_status;
    logic hit_upper;
    logic hit_lower;
    logic hit_adv;
    logic hit_partner;
    logic [15:0] read_word;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers on all port state pins
    assign raw_in = {LP_ABILITY, NEG_RESTART, LINK_UP, FAR_FAULT, NEGOTIATION_DONE};

    // first stage takes the pins, second stage only the first
    always_comb begin
        next_sync1 = raw_in;
        next_sync2 = sync1;
    end

    // synchroniser registers; nothing else reads the first stage
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (CE) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    // enable is synchronised apart since it resets high
    logic [1:0] en1;
    logic [1:0] en2;
    logic [1:0] next_en1;
    logic [1:0] next_en2;
    // enable pair next values
    always_comb begin
        next_en1 = NEG_ENABLE;
        next_en2 = en1;
    end

    // enable pair registers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            en1 <= EN_RESET;
            en2 <= EN_RESET;
        end else if (CE) begin
            en1 <= next_en1;
            en2 <= next_en2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access decode
    assign sel[0] = (PHY_BUS_ADDRESS == phy_mgmt_pkg::PHY_ADDR_PORT1);
    assign sel[1] = (PHY_BUS_ADDRESS == phy_mgmt_pkg::PHY_ADDR_PORT2);
    assign addr_known = |sel;
    // one flag per mapped register index
    assign hit_status = (REGISTER_INDEX == phy_mgmt_pkg::IDX_STATUS);
    assign hit_upper = (REGISTER_INDEX == phy_mgmt_pkg::IDX_IDENT_UPPER);
    assign hit_lower = (REGISTER_INDEX == phy_mgmt_pkg::IDX_IDENT_LOWER);
    assign hit_adv = (REGISTER_INDEX == phy_mgmt_pkg::IDX_ADVERTISE);
    assign hit_partner = (REGISTER_INDEX == phy_mgmt_pkg::IDX_PARTNER);

    // taken requests; a frozen clock enable takes none
    assign rd_taken = RD && CE;
    assign wr_taken = WR && CE && hit_adv;

    ////////////////////////////////////////////////////////////////////////
    // one slice per port; writes to any other index fall away above
    for (genvar p = 0; p < 2; p++) begin : g_port
        assign prt[p].wr_adv = wr_taken && sel[p];
        assign prt[p].wdata = WDATA;
        phy_port_slice u_slice (
            .clk(CLK),
            .reset(RESET),
            .ce(CE),
            .neg_enable(en2[p]),
            .neg_done(sync2[LANE_DONE + p]),
            .far_fault(sync2[LANE_FAULT + p]),
            .link_up(sync2[LANE_LINK + p]),
            .neg_restart(sync2[LANE_RESTART + p]),
            // ability lanes must settle before done rises: no skew guard between them
            .lp_ability(sync2[LANE_ABILITY + ABIL_W * p +: ABIL_W]),
            .regs(prt[p])
        );
        // advertisement in force, pause on top
        assign ADV_ACTIVE[ABIL_W * p +: ABIL_W] = {prt[p].adv_applied[phy_mgmt_pkg::ADV_PAUSE],
                                         prt[p].adv_applied[phy_mgmt_pkg::ADV_100_FULL],
                                         prt[p].adv_applied[phy_mgmt_pkg::ADV_100_HALF],
                                         prt[p].adv_applied[phy_mgmt_pkg::ADV_10_FULL],
                                         prt[p].adv_applied[phy_mgmt_pkg::ADV_10_HALF]};
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unknown address or index reads zero
    logic [15:0] st [2];
    logic [15:0] ad [2];
    logic [15:0] lp [2];
    for (genvar p = 0; p < 2; p++) begin : g_view
        assign st[p] = prt[p].status;
        assign ad[p] = prt[p].advertise;
        assign lp[p] = prt[p].partner;
    end

    // word addressed now; unknown address or index reads zero
    always_comb begin
        read_word = READ_ZERO;
        if (addr_known) begin
            if (hit_status) begin
                read_word = st[sel[1]];
            end else if (hit_upper) begin
                read_word = IDENT_UPPER;
            end else if (hit_lower) begin
                read_word = IDENT_LOWER;
            end else if (hit_adv) begin
                read_word = ad[sel[1]];
            end else if (hit_partner) begin
                read_word = lp[sel[1]];
            end
        end
    end

    // read data holds between reads; a read beside a write sees the old word
    always_comb begin
        next_rdata = rdata;
        next_rvalid = 1'b0;
        if (rd_taken) begin
            next_rvalid = 1'b1;
            next_rdata = read_word;
        end
    end

    // read data registered
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata <= RDATA_RESET;
            rvalid <= 1'b0;
        end else if (CE) begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // data outputs straight from flip-flops
    assign RDATA = rdata;
    assign RVALID = rvalid;
endmodule : phy_mgmt_regs

// ---- dv/phy_mgmt_regs_props.sv ----
// checker: port-level properties of the phy management register bank
module phy_mgmt_regs_props #(
    parameter logic [15:0] IDENT_UPPER = 16'h0000,
    parameter logic [15:0] IDENT_LOWER = 16'h0000
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    // management access
    input wire logic RD,
    input wire logic [4:0] PHY_BUS_ADDRESS,
    input wire logic [4:0] REGISTER_INDEX,
    input wire logic [15:0] RDATA,
    input wire logic RVALID,
    // negotiation side
    input wire logic [1:0] NEG_RESTART,
    input wire logic [9:0] ADV_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // port 1 read taken at this edge
    wire logic rd1 = CE && RD && PHY_BUS_ADDRESS == 5'h01;
    ////////////////////////////////////////////////////////////
    AST_RD_ANSWER: assert property (CE && RD |=> RVALID)
        else $error("read not answered");
    AST_NO_SPURIOUS: assert property (CE && !RD |=> !RVALID)
        else $error("answer without read");
    AST_HALF_10: assert property (rd1 && REGISTER_INDEX == 5'h01 |=> RDATA[11])
        else $error("10 half capable bit low");
    AST_NO_EXT: assert property (rd1 && REGISTER_INDEX == 5'h01 |=> RDATA[1:0] == 2'h0 && !RDATA[6])
        else $error("unsupported status bit set");
    AST_ST_RSVD: assert property (rd1 && REGISTER_INDEX == 5'h01 |=> RDATA[10:7] == 4'h0)
        else $error("status reserved bits set");
    AST_ID_UP: assert property (rd1 && REGISTER_INDEX == 5'h02 |=> RDATA == IDENT_UPPER)
        else $error("upper identifier wrong");
    AST_ID_LO: assert property (rd1 && REGISTER_INDEX == 5'h03 |=> RDATA == IDENT_LOWER)
        else $error("lower identifier wrong");
    AST_ADV_FIXED: assert property (rd1 && REGISTER_INDEX == 5'h04
        |=> RDATA[15:11] == 5'h00 && !RDATA[9] && RDATA[4:0] == 5'h01)
        else $error("advertise fixed bits wrong");
    AST_LP_RSVD: assert property (rd1 && REGISTER_INDEX == 5'h05 |=> !RDATA[15] && !RDATA[9] && RDATA[4:0] == 5'h00)
        else $error("partner reserved bits set");
    AST_UNMAPPED: assert property (CE && RD && REGISTER_INDEX > 5'h05 |=> RDATA == 16'h0000)
        else $error("unmapped index not zero");
    // a write alone must never move the advertisement in force
    AST_ADV_HOLD: assert property (NEG_RESTART == 2'h0 [*4] |=> $stable(ADV_ACTIVE))
        else $error("advertisement changed without restart");
    COV_STATUS: cover property (rd1 && REGISTER_INDEX == 5'h01);
    COV_PARTNER: cover property (rd1 && REGISTER_INDEX == 5'h05);
    COV_RESTART: cover property ($rose(NEG_RESTART[0]));
endmodule : phy_mgmt_regs_props

bind phy_mgmt_regs phy_mgmt_regs_props #(.IDENT_UPPER(IDENT_UPPER), .IDENT_LOWER(IDENT_LOWER)) u_props (
    .CLK(CLK), .RESET(RESET), .CE(CE), .RD(RD), .PHY_BUS_ADDRESS(PHY_BUS_ADDRESS),
    .REGISTER_INDEX(REGISTER_INDEX), .RDATA(RDATA), .RVALID(RVALID), .NEG_RESTART(NEG_RESTART),
    .ADV_ACTIVE(ADV_ACTIVE));

// ---- dv/mgmt_station.sv ----
// partner: management station issuing single register reads and writes
module mgmt_station (
    // clock
    input wire logic clk,
    // access lines
    output logic rd,
    output logic wr,
    output logic [4:0] addr,
    output logic [4:0] idx,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        rd = 1'b0;
        wr = 1'b0;
        addr = 5'h00;
        idx = 5'h00;
        wdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////
    // one access; answer taken one cycle after the request edge
    task automatic access(input logic w, input logic [4:0] a, input logic [4:0] i,
                          input logic [15:0] d, output logic [15:0] r);
        @(posedge clk);
        #1;
        rd = !w;
        wr = w;
        addr = a;
        idx = i;
        wdata = d;
        @(posedge clk);
        #1;
        r = rvalid === 1'b1 || w ? rdata : 16'hXXXX;
        rd = 1'b0;
        wr = 1'b0;
        wdata = ~d; // stale data must not look valid
    endtask : access
endmodule : mgmt_station

// ---- dv/phy_mgmt_status_id_advert_regs_test.sv ----
// testbench: reads, writes, live status and restart of the phy management bank
module phy_mgmt_status_id_advert_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] IDU = 16'hA5C3; // arbitrary value
    localparam logic [15:0] IDL = 16'h3C5A; // arbitrary value
    typedef struct {logic [4:0] a; logic [4:0] i; logic [15:0] e;} row_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic rd, wr, rvalid;
    logic [4:0] addr, idx;
    logic [15:0] wdata, rdata, got;
    logic [1:0] neg_en = 2'b11, done = 2'b00, fault = 2'b00, link = 2'b00, restart = 2'b00;
    logic [9:0] lp = 10'h000;
    logic [9:0] adv;
    int mismatches = 0;
    int compares = 0;
    row_s rows[8] = '{'{5'h01, 5'h01, 16'h7808}, '{5'h01, 5'h02, IDU}, '{5'h01, 5'h03, IDL},
        '{5'h01, 5'h04, 16'h05E1}, '{5'h01, 5'h05, 16'h0000}, '{5'h02, 5'h01, 16'h7808},
        '{5'h03, 5'h01, 16'h0000}, '{5'h01, 5'h1F, 16'h0000}};
    ////////////////////////////////////////////////////////////
    phy_mgmt_regs #(.IDENT_UPPER(IDU), .IDENT_LOWER(IDL)) DUT (.CLK(clk), .RESET(reset), .CE(ce),
        .RD(rd), .WR(wr), .PHY_BUS_ADDRESS(addr), .REGISTER_INDEX(idx), .WDATA(wdata), .RDATA(rdata),
        .RVALID(rvalid), .NEG_ENABLE(neg_en), .NEGOTIATION_DONE(done), .FAR_FAULT(fault), .LINK_UP(link),
        .NEG_RESTART(restart), .LP_ABILITY(lp), .ADV_ACTIVE(adv));
    mgmt_station st (.clk(clk), .rd(rd), .wr(wr), .addr(addr), .idx(idx), .wdata(wdata), .rdata(rdata),
        .rvalid(rvalid));
    // free-running clock
    initial forever #4 clk = ~clk;
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : check
    task automatic final_report;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // watchdog well beyond the roughly fifty cycles needed
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        foreach (rows[k]) begin
            st.access(1'b0, rows[k].a, rows[k].i, 16'h0000, got);
            check(got, rows[k].e);
        end
        // read-only bits and other indices refuse writes
        st.access(1'b1, 5'h01, 5'h04, 16'hFFFF, got);
        st.access(1'b0, 5'h01, 5'h04, 16'h0000, got);
        check(got, 16'h05E1);
        st.access(1'b1, 5'h01, 5'h04, 16'h0000, got);
        st.access(1'b1, 5'h01, 5'h01, 16'hFFFF, got);
        st.access(1'b0, 5'h01, 5'h04, 16'h0000, got);
        check(got, 16'h0001);
        check({6'h00, adv}, 16'h03FF);
        // frozen clock enable takes no write
        ce = 1'b0;
        st.access(1'b1, 5'h01, 5'h04, 16'hFFFF, got);
        ce = 1'b1;
        st.access(1'b0, 5'h01, 5'h04, 16'h0000, got);
        check(got, 16'h0001);
        restart = 2'b01;
        repeat (4) @(posedge clk);
        #1 restart = 2'b00;
        check({6'h00, adv}, 16'h03E0);
        // live port 1 state; partner ability latched on done
        lp = 10'h011;
        neg_en = 2'b10;
        fault = 2'b01;
        link = 2'b01;
        repeat (3) @(posedge clk);
        #1 done = 2'b01;
        repeat (3) @(posedge clk);
        st.access(1'b0, 5'h01, 5'h01, 16'h0000, got);
        check(got, 16'h7834);
        st.access(1'b0, 5'h02, 5'h01, 16'h0000, got);
        check(got, 16'h7808);
        st.access(1'b0, 5'h01, 5'h05, 16'h0000, got);
        check(got, 16'h0420);
        // second reset restores the default advertisement
        reset = 1'b1;
        @(posedge clk);
        #1 reset = 1'b0;
        check({6'h00, adv}, 16'h03FF);
        st.access(1'b0, 5'h01, 5'h04, 16'h0000, got);
        check(got, 16'h05E1);
        final_report();
    end
endmodule : phy_mgmt_status_id_advert_regs_test
